// *** dv/tb_top.sv ***
// Self-checking bench for the ignition power sequencer
`timescale 1ns/10ps
module tb_top;
   import vips_pkg::*;
   localparam int unsigned T = 10;
   logic        ref_clk_in;
   logic        sys_rst_in;
   logic        ce_in;
   logic        ignition_in;
   logic        mode_24v_in;
   logic        cfg_load_in;
   vips_volt_t  supply_volt_in;
   vips_wait_t  on_wait_in;
   vips_wait_t  notice_wait_in;
   vips_wait_t  cutoff_wait_in;
   vips_wait_t  lv_wait_in;
   vips_wait_t  lv_cutoff_wait_in;
   vips_volt_t  thr12_in;
   vips_volt_t  thr24_in;
   logic        sys_power_out;
   logic        pwr_button_out;
   vips_state_t state_out;
   vips_wait_t  remain_out;
   logic [7:0]  press_count;
   logic        bad_press;
   int unsigned errors;
   int unsigned num_checks;
   int unsigned cycles;
   int unsigned n;

   vips_sequencer #(.TICK_CYCLES_P(T)) dut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
      .ce_in(ce_in), .ignition_in(ignition_in), .supply_volt_in(supply_volt_in),
      .mode_24v_in(mode_24v_in), .cfg_load_in(cfg_load_in), .on_wait_in(on_wait_in),
      .notice_wait_in(notice_wait_in), .cutoff_wait_in(cutoff_wait_in),
      .lv_wait_in(lv_wait_in), .lv_cutoff_wait_in(lv_cutoff_wait_in), .thr12_in(thr12_in),
      .thr24_in(thr24_in), .sys_power_out(sys_power_out), .pwr_button_out(pwr_button_out),
      .state_out(state_out), .remain_out(remain_out));

   vips_host_model host (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
      .sys_power_in(sys_power_out), .pwr_button_in(pwr_button_out),
      .press_count_out(press_count), .bad_press_out(bad_press));

   // Clock at 200 MHz
   initial
   begin
      ref_clk_in = 1'b0;
      forever #2.5 ref_clk_in = ~ref_clk_in;
   end

   // Compare one value and count the result
   task automatic chk(input logic [14:0] got, input logic [14:0] exp);
      num_checks++;
      if (got !== exp)
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      if (got !== exp)
         errors++;
   endtask : chk

   // Wait a bounded number of edges for a state, returning the edge count
   task automatic wait_st(input vips_state_t s, input int unsigned lim, output int unsigned c);
      c = 0;
      while (state_out !== s && c < lim)
      begin
         @(posedge ref_clk_in);
         #1;
         c++;
      end
      chk(15'(state_out), 15'(s));
   endtask : wait_st

   // Drive ignition, supply and mode together at one edge
   task automatic set_in(input logic ign, input vips_volt_t sup, input logic m24);
      @(posedge ref_clk_in);
      ignition_in    <= ign;
      supply_volt_in <= sup;
      mode_24v_in    <= m24;
   endtask : set_in

   // Load all seven settings with a one-cycle strobe
   task automatic cfg(input vips_wait_t w_on, w_nt, w_cu, w_lv, w_lc, input vips_volt_t t12,
                      input vips_volt_t t24);
      @(posedge ref_clk_in);
      on_wait_in        <= w_on;
      notice_wait_in    <= w_nt;
      cutoff_wait_in    <= w_cu;
      lv_wait_in        <= w_lv;
      lv_cutoff_wait_in <= w_lc;
      thr12_in          <= t12;
      thr24_in          <= t24;
      cfg_load_in       <= 1'b1;
      @(posedge ref_clk_in);
      cfg_load_in       <= 1'b0;
   endtask : cfg

   // Let some edges pass and settle
   task automatic idle(input int unsigned c);
      repeat (c) @(posedge ref_clk_in);
      #1;
   endtask : idle

   // Print the counts and the verdict, then stop
   task automatic results();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : results

   // Hang guard
   always @(posedge ref_clk_in)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         results();
      end
   end

   // Main sequence
   initial
   begin
      errors = 0;
      num_checks = 0;
      cycles = 0;
      sys_rst_in = 1'b1;
      ce_in = 1'b1;
      ignition_in = 1'b0;
      mode_24v_in = 1'b0;
      cfg_load_in = 1'b0;
      supply_volt_in = 12'h0514;
      on_wait_in = ON_WAIT_DEF;
      notice_wait_in = NOTICE_WAIT_DEF;
      cutoff_wait_in = CUTOFF_WAIT_DEF;
      lv_wait_in = LV_WAIT_DEF;
      lv_cutoff_wait_in = LV_CUTOFF_DEF;
      thr12_in = THR12_DEF;
      thr24_in = THR24_DEF;
      repeat (20) @(posedge ref_clk_in);
      sys_rst_in <= 1'b0;
      #1;
      chk(15'(state_out), 15'(VIPS_OFF));
      chk(15'({sys_power_out, pwr_button_out}), 15'h0000);
      chk(remain_out, 15'h0000);
      set_in(1'b1, 12'h0514, 1'b0);
      wait_st(VIPS_ON_WAIT, 8, n);
      chk(remain_out, 15'h0002);
      wait_st(VIPS_ON, 3 * T, n);
      chk(15'(n), 15'(2 * T));
      chk(15'(sys_power_out), 15'h0001);
      set_in(1'b1, 12'h0476, 1'b0);
      idle(20);
      chk(15'(state_out), 15'(VIPS_ON));
      set_in(1'b1, 12'h0475, 1'b0);
      wait_st(VIPS_LV_NOTICE, 4, n);
      chk(remain_out, 15'h001E);
      set_in(1'b1, 12'h0476, 1'b0);
      wait_st(VIPS_ON, 4, n);
      set_in(1'b0, 12'h0514, 1'b0);
      wait_st(VIPS_NOTICE, 8, n);
      chk(remain_out, 15'h0005);
      idle(25);
      set_in(1'b1, 12'h0514, 1'b0);
      wait_st(VIPS_ON, 8, n);
      chk(15'(sys_power_out), 15'h0001);
      chk(remain_out, 15'h0005);
      set_in(1'b0, 12'h0514, 1'b0);
      wait_st(VIPS_NOTICE, 8, n);
      wait_st(VIPS_CUTOFF, 6 * T, n);
      chk(15'(n), 15'(5 * T));
      chk(15'(pwr_button_out), 15'h0001);
      chk(remain_out, 15'h003C);
      set_in(1'b1, 12'h0514, 1'b0);
      wait_st(VIPS_OFF, 61 * T, n);
      chk(15'(sys_power_out), 15'h0000);
      chk(15'(press_count), 15'h0001);
      idle(30);
      chk(15'(state_out), 15'(VIPS_OFF));
      set_in(1'b0, 12'h0514, 1'b0);
      cfg(15'h0000, 15'h4E20, 15'h0002, 15'h0FA0, 15'h0002, 12'h0000, 12'h0FFF);
      set_in(1'b1, 12'h03F1, 1'b0);
      wait_st(VIPS_ON_WAIT, 8, n);
      chk(remain_out, 15'h0001);
      wait_st(VIPS_ON, 2 * T, n);
      idle(20);
      chk(15'(state_out), 15'(VIPS_ON));
      set_in(1'b1, 12'h03F0, 1'b0);
      wait_st(VIPS_LV_NOTICE, 4, n);
      chk(remain_out, 15'h0E10);
      set_in(1'b1, 12'h03F1, 1'b1);
      idle(5);
      chk(15'(state_out), 15'(VIPS_LV_NOTICE));
      // Clock enable low freezes the notice although the supply recovers
      @(posedge ref_clk_in);
      ce_in <= 1'b0;
      set_in(1'b1, 12'h0918, 1'b1);
      idle(12);
      chk(15'(state_out), 15'(VIPS_LV_NOTICE));
      @(posedge ref_clk_in);
      ce_in <= 1'b1;
      wait_st(VIPS_ON, 4, n);
      cfg(15'h0001, 15'h4E20, 15'h0002, 15'h0002, 15'h0002, 12'h0000, 12'h0FFF);
      set_in(1'b1, 12'h0917, 1'b1);
      wait_st(VIPS_LV_NOTICE, 4, n);
      chk(remain_out, 15'h0002);
      set_in(1'b0, 12'h0917, 1'b1);
      wait_st(VIPS_LV_CUTOFF, 3 * T, n);
      chk(15'(pwr_button_out), 15'h0001);
      wait_st(VIPS_OFF, 3 * T, n);
      chk(15'(n), 15'(2 * T));
      chk(15'(press_count), 15'h0002);
      chk(15'(sys_power_out), 15'h0000);
      chk(15'(bad_press), 15'h0000);
      results();
   end
endmodule : tb_top

// *** dv/vips_host_model.sv ***
// Host computer model: counts power-button events and flags bad presses
`timescale 1ns/10ps
module vips_host_model
(
   input  wire logic  ref_clk_in,
   input  wire logic  sys_rst_in,
   input  wire logic  sys_power_in,
   input  wire logic  pwr_button_in,
   output logic [7:0] press_count_out,
   output logic       bad_press_out
);
   logic button_prev_q;

   // Edge counter for presses; a held or unpowered press is flagged
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
      begin
         press_count_out <= 8'h00;
         bad_press_out   <= 1'b0;
         button_prev_q   <= 1'b0;
      end
      else
      begin
         button_prev_q <= pwr_button_in;
         if (pwr_button_in && !button_prev_q)
            press_count_out <= press_count_out + 8'h01;
         if (pwr_button_in && (button_prev_q || !sys_power_in))
            bad_press_out <= 1'b1;
      end
   end
endmodule : vips_host_model

// *** src/vips_pkg.sv ***
// Constants and types shared by the ignition power sequencer files
package vips_pkg;
   // Clock rate and the length of one countdown step
   localparam int unsigned CLK_HZ        = 200_000_000;
   localparam int unsigned TICK_PERIOD_S = 1;
   localparam int unsigned TICK_CYCLES   = CLK_HZ * TICK_PERIOD_S;

   // Wait counters count whole seconds
   localparam int unsigned WAIT_W = 15;
   typedef logic [WAIT_W-1:0] vips_wait_t;

   // Wait defaults after reset, in seconds
   localparam vips_wait_t ON_WAIT_DEF     = 15'h0002;
   localparam vips_wait_t NOTICE_WAIT_DEF = 15'h0005;
   localparam vips_wait_t CUTOFF_WAIT_DEF = 15'h003C;
   localparam vips_wait_t LV_WAIT_DEF     = 15'h001E;
   localparam vips_wait_t LV_CUTOFF_DEF   = 15'h003C;

   // Accepted wait ranges, in seconds
   localparam vips_wait_t WAIT_MIN    = 15'h0001;
   localparam vips_wait_t WAIT_MAX    = 15'h4650;
   localparam vips_wait_t LV_WAIT_MAX = 15'h0E10;

   // Supply voltage code, in units of 10 mV
   localparam int unsigned VOLT_W = 12;
   typedef logic [VOLT_W-1:0] vips_volt_t;

   // Undervoltage thresholds, defaults and ranges per supply mode
   localparam vips_volt_t THR12_DEF = 12'h0476;
   localparam vips_volt_t THR12_MIN = 12'h03F1;
   localparam vips_volt_t THR12_MAX = 12'h04C9;
   localparam vips_volt_t THR24_DEF = 12'h08C4;
   localparam vips_volt_t THR24_MIN = 12'h083F;
   localparam vips_volt_t THR24_MAX = 12'h0918;

   // Sequencer states, Gray coded along the usual path
   typedef enum logic [2:0] {
      VIPS_OFF       = 3'h0,
      VIPS_ON_WAIT   = 3'h1,
      VIPS_ON        = 3'h3,
      VIPS_NOTICE    = 3'h2,
      VIPS_CUTOFF    = 3'h6,
      VIPS_LV_NOTICE = 3'h7,
      VIPS_LV_CUTOFF = 3'h5
   } vips_state_t;
endpackage : vips_pkg

// *** src/vips_sec_tick.sv ***
// One-second tick prescaler with restart
`timescale 1ns/10ps
module vips_sec_tick
#(
   parameter int unsigned CYCLES = 200_000_000
)
(
   input  wire logic ref_clk_in,
   input  wire logic sys_rst_in,
   input  wire logic ce_in,
   input  wire logic restart_in,
   output logic      tick_out
);
   localparam int unsigned W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
   localparam logic [W-1:0] LAST = W'(CYCLES - 1);

   logic [W-1:0] div_q;

   // Divider restarts so each countdown step is a full second
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in || restart_in)
      begin
         div_q <= '0;
      end
      else if (ce_in)
      begin
         div_q <= (div_q == LAST) ? '0 : div_q + W'(1);
      end
   end

   // Tick marks the last cycle of each second; it does not look at the restart,
   // because the restart is itself decoded from the tick in the sequencer and
   // gating it here would close a combinational loop. A load overrides the step.
   assign tick_out = ce_in && (div_q == LAST);
endmodule : vips_sec_tick

// *** src/vips_sequencer.sv ***
// Ignition and undervoltage power sequencer for the host computer
`timescale 1ns/10ps
module vips_sequencer
   import vips_pkg::*;
#(
   parameter int unsigned TICK_CYCLES_P = vips_pkg::TICK_CYCLES
)
(
   input  wire logic                 ref_clk_in,
   input  wire logic                 sys_rst_in,
   input  wire logic                 ce_in,
   input  wire logic                 ignition_in,
   input  wire vips_pkg::vips_volt_t supply_volt_in,
   input  wire logic                 mode_24v_in,
   input  wire logic                 cfg_load_in,
   input  wire vips_pkg::vips_wait_t on_wait_in,
   input  wire vips_pkg::vips_wait_t notice_wait_in,
   input  wire vips_pkg::vips_wait_t cutoff_wait_in,
   input  wire vips_pkg::vips_wait_t lv_wait_in,
   input  wire vips_pkg::vips_wait_t lv_cutoff_wait_in,
   input  wire vips_pkg::vips_volt_t thr12_in,
   input  wire vips_pkg::vips_volt_t thr24_in,
   output logic                      sys_power_out,
   output logic                      pwr_button_out,
   output vips_pkg::vips_state_t     state_out,
   output vips_pkg::vips_wait_t      remain_out
);
   import vips_pkg::*;

   // Limit a value to an accepted range
   function automatic logic [WAIT_W-1:0] clamp_w(input logic [WAIT_W-1:0] v,
                                                 input logic [WAIT_W-1:0] hi);
      clamp_w = (v < WAIT_MIN) ? WAIT_MIN : ((v > hi) ? hi : v);
   endfunction : clamp_w

   function automatic logic [VOLT_W-1:0] clamp_v(input logic [VOLT_W-1:0] v,
                                                 input logic [VOLT_W-1:0] lo,
                                                 input logic [VOLT_W-1:0] hi);
      clamp_v = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction : clamp_v

   logic        ign_m_q;
   logic        ign_s_q;
   logic        arm_q;
   vips_wait_t  on_w_q;
   vips_wait_t  notice_w_q;
   vips_wait_t  cutoff_w_q;
   vips_wait_t  lv_w_q;
   vips_wait_t  lv_cut_w_q;
   vips_volt_t  thr12_q;
   vips_volt_t  thr24_q;
   vips_state_t st_q;
   vips_state_t st_d;
   vips_wait_t  cnt_q;
   vips_wait_t  cnt_d;
   logic        power_q;
   logic        button_q;
   logic        button_d;
   logic        restart;
   logic        tick;
   logic        expire;
   logic        below;

   // Ignition pin synchroniser
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
      begin
         ign_m_q <= 1'b0;
         ign_s_q <= 1'b0;
      end
      else if (ce_in)
      begin
         ign_m_q <= ignition_in;
         ign_s_q <= ign_m_q;
      end
   end

   // Captured settings, clamped into their accepted ranges
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
      begin
         on_w_q     <= ON_WAIT_DEF;
         notice_w_q <= NOTICE_WAIT_DEF;
         cutoff_w_q <= CUTOFF_WAIT_DEF;
         lv_w_q     <= LV_WAIT_DEF;
         lv_cut_w_q <= LV_CUTOFF_DEF;
         thr12_q    <= THR12_DEF;
         thr24_q    <= THR24_DEF;
      end
      else if (ce_in && cfg_load_in)
      begin
         on_w_q     <= clamp_w(on_wait_in, WAIT_MAX);
         notice_w_q <= clamp_w(notice_wait_in, WAIT_MAX);
         cutoff_w_q <= clamp_w(cutoff_wait_in, WAIT_MAX);
         lv_w_q     <= clamp_w(lv_wait_in, LV_WAIT_MAX);
         lv_cut_w_q <= clamp_w(lv_cutoff_wait_in, LV_WAIT_MAX);
         thr12_q    <= clamp_v(thr12_in, THR12_MIN, THR12_MAX);
         thr24_q    <= clamp_v(thr24_in, THR24_MIN, THR24_MAX);
      end
   end

   // Supply compare against the threshold of the selected mode
   assign below  = supply_volt_in < (mode_24v_in ? thr24_q : thr12_q);

   // Second tick; restarted whenever a countdown is loaded, except the notice-wait reload on return to VIPS_ON
   vips_sec_tick #(
      .CYCLES     (TICK_CYCLES_P)
   ) u_tick (
      .ref_clk_in (ref_clk_in),
      .sys_rst_in (sys_rst_in),
      .ce_in      (ce_in),
      .restart_in (restart),
      .tick_out   (tick)
   );

   assign expire = tick && (cnt_q <= WAIT_MIN);

   // Next state, countdown load and button event
   always_comb
   begin
      st_d     = st_q;
      cnt_d    = cnt_q;
      button_d = 1'b0;
      restart  = 1'b0;
      if (tick && !expire)
      begin
         cnt_d = cnt_q - WAIT_MIN;
      end
      unique case (st_q)
         VIPS_OFF:
         begin
            if (ign_s_q && arm_q)
            begin
               st_d    = VIPS_ON_WAIT;
               cnt_d   = on_w_q;
               restart = 1'b1;
            end
         end
         VIPS_ON_WAIT:
         begin
            if (!ign_s_q)
            begin
               st_d = VIPS_OFF;
            end
            else if (expire)
            begin
               st_d = VIPS_ON;
            end
         end
         VIPS_ON:
         begin
            if (!ign_s_q)
            begin
               st_d    = VIPS_NOTICE;
               cnt_d   = notice_w_q;
               restart = 1'b1;
            end
            else if (below)
            begin
               st_d    = VIPS_LV_NOTICE;
               cnt_d   = lv_w_q;
               restart = 1'b1;
            end
         end
         VIPS_NOTICE:
         begin
            if (ign_s_q)
            begin
               st_d  = VIPS_ON;
               cnt_d = notice_w_q;
            end
            else if (expire)
            begin
               st_d     = VIPS_CUTOFF;
               cnt_d    = cutoff_w_q;
               button_d = 1'b1;
               restart  = 1'b1;
            end
         end
         VIPS_CUTOFF:
         begin
            if (expire)
            begin
               st_d = VIPS_OFF;
            end
         end
         VIPS_LV_NOTICE:
         begin
            if (!below)
            begin
               st_d = VIPS_ON;
            end
            else if (expire)
            begin
               st_d     = VIPS_LV_CUTOFF;
               cnt_d    = lv_cut_w_q;
               button_d = 1'b1;
               restart  = 1'b1;
            end
         end
         VIPS_LV_CUTOFF:
         begin
            if (expire)
            begin
               st_d = VIPS_OFF;
            end
         end
         default:
         begin
            st_d = VIPS_OFF;
         end
      endcase
      if (!ce_in)
      begin
         st_d     = st_q;
         cnt_d    = cnt_q;
         button_d = 1'b0;
         restart  = 1'b0;
      end
   end

   // Sequencer state, countdown and button pulse
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
      begin
         st_q     <= VIPS_OFF;
         cnt_q    <= '0;
         button_q <= 1'b0;
      end
      else
      begin
         st_q     <= st_d;
         cnt_q    <= cnt_d;
         button_q <= button_d;
      end
   end

   // Power switch follows the powered states
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
      begin
         power_q <= 1'b0;
      end
      else
      begin
         power_q <= (st_d != VIPS_OFF) && (st_d != VIPS_ON_WAIT);
      end
   end

   // After a cutoff the ignition must drop before a new power-up
   always_ff @(posedge ref_clk_in)
   begin
      if (sys_rst_in)
      begin
         arm_q <= 1'b1;
      end
      else if (ce_in)
      begin
         if (!ign_s_q)
         begin
            arm_q <= 1'b1;
         end
         else if (st_q != VIPS_OFF && st_d == VIPS_OFF)
         begin
            arm_q <= 1'b0;
         end
      end
   end

   assign sys_power_out  = power_q;
   assign pwr_button_out = button_q;
   assign state_out      = st_q;
   assign remain_out     = cnt_q;

   sequence s_lv_expire;
      st_q == VIPS_LV_NOTICE && ce_in && below && expire;
   endsequence
   sequence s_lv_cut_start;
      st_q == VIPS_LV_CUTOFF && button_q && cnt_q == lv_cut_w_q;
   endsequence

   a_power_on_expiry: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      (st_q == VIPS_ON_WAIT && ce_in && ign_s_q && expire) |=> (st_q == VIPS_ON && power_q))
      else $error("power-on wait expiry did not power the system");
   a_notice_start: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      (st_q == VIPS_ON && ce_in && !ign_s_q) |=> (st_q == VIPS_NOTICE && cnt_q == notice_w_q))
      else $error("ignition off did not start the notice wait");
   a_notice_abort: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      (st_q == VIPS_NOTICE && ce_in && ign_s_q) |=> (st_q == VIPS_ON && power_q
                                                     && cnt_q == notice_w_q))
      else $error("ignition return did not abort the notice wait");
   a_notice_button: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      (st_q == VIPS_NOTICE && ce_in && !ign_s_q && expire) |=>
         (st_q == VIPS_CUTOFF && button_q && cnt_q == cutoff_w_q) ##1 !button_q)
      else $error("notice expiry did not give one button pulse");
   a_cutoff_locked: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      (st_q == VIPS_CUTOFF && !(ce_in && expire)) |=> (st_q == VIPS_CUTOFF && power_q))
      else $error("forced cutoff left early");
   a_cutoff_drop: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      (st_q == VIPS_CUTOFF && ce_in && expire) |=> (!power_q && st_q == VIPS_OFF))
      else $error("forced cutoff expiry kept power");
   a_lv_start: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      (st_q == VIPS_ON && ce_in && ign_s_q && below) |=> (st_q == VIPS_LV_NOTICE
                                                          && cnt_q == lv_w_q))
      else $error("low supply did not start the undervoltage notice");
   a_lv_recover: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      (st_q == VIPS_LV_NOTICE && ce_in && !below) |=> (st_q == VIPS_ON && power_q))
      else $error("supply recovery did not end the undervoltage notice");
   a_lv_button: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      s_lv_expire |=> s_lv_cut_start)
      else $error("undervoltage notice expiry did not start cutoff");
   a_lv_cut_drop: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      (st_q == VIPS_LV_CUTOFF && ce_in && expire) |=> (!power_q ##1 !power_q))
      else $error("undervoltage cutoff expiry kept power");
   a_wait_range: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      on_w_q >= WAIT_MIN && on_w_q <= WAIT_MAX && notice_w_q >= WAIT_MIN
      && notice_w_q <= WAIT_MAX && cutoff_w_q >= WAIT_MIN && cutoff_w_q <= WAIT_MAX
      && lv_w_q >= WAIT_MIN && lv_w_q <= LV_WAIT_MAX && lv_cut_w_q >= WAIT_MIN
      && lv_cut_w_q <= LV_WAIT_MAX)
      else $error("wait setting outside accepted range");
   a_thr_range: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      thr12_q >= THR12_MIN && thr12_q <= THR12_MAX && thr24_q >= THR24_MIN
      && thr24_q <= THR24_MAX)
      else $error("threshold outside accepted range");
   a_count_step: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      (tick && !expire && st_d == st_q && !restart) |=> (cnt_q == $past(cnt_q) - WAIT_MIN))
      else $error("countdown did not step by one on the tick");
   a_reset_off: assert property (@(posedge ref_clk_in)
      sys_rst_in |=> (st_q == VIPS_OFF && !power_q && on_w_q == ON_WAIT_DEF))
      else $error("reset did not return to off with defaults");
endmodule : vips_sequencer
